// [lsst_timing_map.vh]
// timing constants for the linear sensor scan timing generator
`ifndef LSST_TIMING_MAP_VH
`define LSST_TIMING_MAP_VH
// pixel period in base clock cycles
`define LSST_PIXEL_CYCLES   3'h6
`define LSST_PHASE_LAST     3'h5
// second shift clock high in phases 0..3
`define LSST_SH2_LAST       3'h3
// reset pulse high in phases 2..4
`define LSST_RST_FIRST      3'h2
`define LSST_RST_LAST       3'h4
// trigger high in phases 1..3
`define LSST_TRG_FIRST      3'h1
`define LSST_TRG_LAST       3'h3
// scan start width in cycles
`define LSST_START_CYCLES   2'h2
// end-of-scan width in cycles
`define LSST_DONE_CYCLES    3'h4
// default pixels per scan
`define LSST_PIXELS         10'h200
`endif

// [lsst_phase_gen.v]
// per-pixel phase counter and pulse decode
`timescale 1ns/1ps
`default_nettype none
`include "lsst_timing_map.vh"
module lsst_phase_gen (
  // clock and control
  input  wire       clock,
  input  wire       rst,
  input  wire       clkEn,
  input  wire       restart,
  // phase and decoded pulses
  output reg  [2:0] phase,
  output wire       pixelEnd,
  output wire       shift2,
  output wire       resetHigh,
  output wire       trigHigh
);
  wire [2:0] next_phase;

  assign pixelEnd   = (phase == `LSST_PHASE_LAST);
  assign next_phase = (restart | pixelEnd) ? 3'h0 : phase + 3'h1;

  assign shift2    = (phase <= `LSST_SH2_LAST);
  assign resetHigh = (phase >= `LSST_RST_FIRST) && (phase <= `LSST_RST_LAST);
  assign trigHigh  = (phase >= `LSST_TRG_FIRST) && (phase <= `LSST_TRG_LAST);

  always @(posedge clock) begin
    if (rst) begin
      phase <= 3'h0;
    end else if (clkEn) begin
      phase <= next_phase;
    end
  end
endmodule // lsst_phase_gen
`default_nettype wire

// [lsst_scan_timing.v]
// scan timing generator for a voltage-output linear photodiode sensor
// What this block does
// - pulses follow fixed schedule, one-cycle steps
// - start falling edge gives two-cycle scan start
// - every start restarts a full scan
// - each pixel takes six cycles
// - drive pulses repeat every pixel period
// - complementary shift clocks, two and four high
// - outputs referenced to second shift clock
// - reset high three cycles, two overlapping
// - reset falls one cycle before shift rise
// - video valid shift rise to reset rise
// - trigger rises phase one, three cycles high
// - end-of-scan low four cycles, right after last pixel
// - start initialises all pulse state
// - trigger active high, done active low
`timescale 1ns/1ps
`default_nettype none
`include "lsst_timing_map.vh"
module lsst_scan_timing #(
  parameter [9:0] PIXELS = `LSST_PIXELS
) (
  // clock, reset, enable
  input  wire clock,
  input  wire rst,
  input  wire clkEn,
  // start from pulse source
  input  wire frameStartIn,
  // sensor drive
  output reg  sensorScanStart,
  output reg  shiftClk1,
  output reg  shiftClk2,
  output reg  resetPulse,
  // converter and external flags
  output reg  convTrig,
  output reg  scanDone_n
);
  // ----------------------------------------
  // start edge and counters
  // ----------------------------------------
  reg        startPrev;
  reg  [1:0] startCnt;
  reg  [9:0] pixelCnt;
  reg        scanning;
  reg  [2:0] doneCnt;
  wire [2:0] phase;
  wire       pixelEnd;
  wire       shift2;
  wire       resetHigh;
  wire       trigHigh;
  wire       startFall = startPrev & ~frameStartIn;
  wire       lastPixel = scanning && pixelEnd && (pixelCnt == PIXELS - 10'h1);

  lsst_phase_gen uPhase (
    .clock     (clock),
    .rst       (rst),
    .clkEn     (clkEn),
    .restart   (startFall),
    .phase     (phase),
    .pixelEnd  (pixelEnd),
    .shift2    (shift2),
    .resetHigh (resetHigh),
    .trigHigh  (trigHigh)
  );

  // ----------------------------------------
  // scan sequencing
  // ----------------------------------------
  // input is taken as synchronous, so one register suffices for the edge
  always @(posedge clock) begin
    if (rst) begin
      startPrev       <= 1'b0;
      startCnt        <= 2'h0;
      pixelCnt        <= 10'h0;
      scanning        <= 1'b0;
      doneCnt         <= 3'h0;
      sensorScanStart <= 1'b0;
      shiftClk1       <= 1'b0;
      shiftClk2       <= 1'b0;
      resetPulse      <= 1'b0;
      convTrig        <= 1'b0;
      scanDone_n      <= 1'b1;
    end else if (clkEn) begin
      startPrev <= frameStartIn;
      if (startFall) begin
        startCnt <= `LSST_START_CYCLES;
      end else if (startCnt != 2'h0) begin
        startCnt <= startCnt - 2'h1;
      end
      sensorScanStart <= startFall | (startCnt > 2'h1);
      if (startFall) begin
        pixelCnt <= 10'h0;
        scanning <= 1'b1;
        doneCnt  <= 3'h0;
      end else begin
        if (lastPixel) begin
          scanning <= 1'b0;
          pixelCnt <= 10'h0;
        end else if (scanning && pixelEnd) begin
          pixelCnt <= pixelCnt + 10'h1;
        end
        // done aligned to shift period start
        if (lastPixel) begin
          doneCnt <= `LSST_DONE_CYCLES;
        end else if (doneCnt != 3'h0) begin
          doneCnt <= doneCnt - 3'h1;
        end
      end
      // outputs registered from the decoded phase; restart forces phase 0 look
      // one-cycle step schedule
      shiftClk2  <= startFall | pixelEnd ? 1'b1 : (phase < `LSST_SH2_LAST);
      shiftClk1  <= startFall | pixelEnd ? 1'b0 : ~(phase < `LSST_SH2_LAST);
      resetPulse <= ~(startFall | pixelEnd) && (phase >= `LSST_RST_FIRST - 3'h1) &&
                    (phase <= `LSST_RST_LAST - 3'h1);
      convTrig   <= ~(startFall | pixelEnd) && (phase >= `LSST_TRG_FIRST - 3'h1) &&
                    (phase <= `LSST_TRG_LAST - 3'h1);
      scanDone_n <= ~(startFall ? 1'b0 : (lastPixel | (doneCnt > 3'h1)));
    end
  end
endmodule // lsst_scan_timing
`default_nettype wire

// [lsst_pulse_src.sv]
// pulse source model driving the frame start
`timescale 1ns/1ps
`default_nettype none
module lsst_pulse_src (
  // clock and request
  input  wire logic clock,
  input  wire logic fire,
  // start towards the block
  output var  logic frameStartIn
);
  logic hold = 1'b0;
  initial frameStartIn = 1'b0;
  always @(negedge clock) begin
    hold <= fire;
    frameStartIn <= fire | hold;
  end
endmodule // lsst_pulse_src
`default_nettype wire

// [lsst_scan_timing_assertions.sv]
// checker for the scan timing generator
`timescale 1ns/1ps
`default_nettype none
module lsst_checker #(parameter [9:0] PIXELS = 10'h200) (
  input wire logic clock, rst, clkEn, frameStartIn,
  input wire logic sensorScanStart, shiftClk1, shiftClk2, resetPulse, convTrig, scanDone_n
);
  localparam int SCAN = 6 * PIXELS;
  logic armed;
  // free-running phase is arbitrary until a start aligns it
  always @(posedge clock) armed <= rst ? 1'b0 : (armed | sensorScanStart);
  default clocking @(posedge clock); endclocking
  // a frozen enable stalls every pulse, so attempts spanning a freeze are dropped
  default disable iff (rst || !clkEn);
  start_width_a: assert property ($rose(sensorScanStart) |=> sensorScanStart ##1 !sensorScanStart)
    else $error("scan start width wrong");
  start_cause_a: assert property ($fell(frameStartIn) |-> ##[1:3] $rose(sensorScanStart))
    else $error("start fall without scan start");
  shift_comp_a: assert property (!$past(rst) |-> shiftClk1 ^ shiftClk2)
    else $error("shift clocks not complementary");
  shift_period_a: assert property (armed && $rose(shiftClk2) |=> shiftClk2[*3] ##1 !shiftClk2[*2] ##1 shiftClk2)
    else $error("shift clock period wrong");
  reset_phase_a: assert property (armed && $rose(shiftClk2) |-> !resetPulse[*2] ##1 resetPulse[*3] ##1 !resetPulse)
    else $error("reset pulse phase wrong");
  reset_fall_a: assert property (armed && $fell(resetPulse) |-> !shiftClk2 ##1 $rose(shiftClk2))
    else $error("reset fall not one cycle early");
  trig_phase_a: assert property (armed && $rose(shiftClk2) |-> !convTrig ##1 convTrig[*3] ##1 !convTrig)
    else $error("trigger phase wrong");
  done_width_a: assert property ($fell(scanDone_n) |-> $rose(shiftClk2) ##1 !scanDone_n[*3] ##1 scanDone_n)
    else $error("end of scan width wrong");
  done_count_a: assert property ($fell(scanDone_n) |-> $past(sensorScanStart, SCAN) && !$past(sensorScanStart, SCAN + 1))
    else $error("end of scan at wrong pixel");
  cover property ($rose(sensorScanStart));
  cover property ($fell(scanDone_n));
  cover property (armed && $fell(frameStartIn) && scanDone_n);
endmodule // lsst_checker
bind lsst_scan_timing lsst_checker #(.PIXELS(PIXELS)) chk (.*);
`default_nettype wire

// [linear_sensor_scan_timing_test.sv]
// self-checking bench for the scan timing generator
`timescale 1ns/1ps
`default_nettype none
module linear_sensor_scan_timing_test;
  localparam [9:0] PIX = 10'h004;
  logic clock = 1'b0, rst = 1'b1, fire = 1'b0, clkEn = 1'b1;
  logic [5:0] held;
  wire frameStartIn, sensorScanStart, shiftClk1, shiftClk2, resetPulse, convTrig, scanDone_n;
  wire [5:0] outs = {sensorScanStart, shiftClk1, shiftClk2, resetPulse, convTrig, scanDone_n};
  int n_mismatch = 0, check_count = 0, t = -1, nRise = 0, nFire = 0, k;
  logic [31:0] seed = 32'h0001_1692;
  // bench clock stands in for a master clock scaled to the pixel limit
  always #50 clock = ~clock;
  lsst_scan_timing #(.PIXELS(PIX)) DUT (.clock(clock), .rst(rst), .clkEn(clkEn), .frameStartIn(frameStartIn),
    .sensorScanStart(sensorScanStart), .shiftClk1(shiftClk1), .shiftClk2(shiftClk2),
    .resetPulse(resetPulse), .convTrig(convTrig), .scanDone_n(scanDone_n));
  lsst_pulse_src src (.clock(clock), .fire(fire), .frameStartIn(frameStartIn));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected {start, shift1, shift2, reset, trigger, done_n} at cycle n of a scan
  function automatic logic [5:0] expv(input int n);
    int p;
    p = n % 6;
    return {n < 2, p > 3, p < 4, p > 1 && p < 5, p > 0 && p < 4, !(n / 6 == PIX && p < 4)};
  endfunction
  task automatic chk(input logic [5:0] s, e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic tick(input logic f);
    @(negedge clock);
    if (sensorScanStart === 1'b1 && (t < 0 || t > 1)) begin
      t = 0;
      nRise++;
    end
    // all six outputs are sampled at every falling clock edge once a scan start is seen, held to expv
    if (t >= 0) chk(outs, expv(t));
    if (t >= 0) t++;
    fire <= f;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clock);
    chk(outs, 6'h01);
    rst = 1'b0;
    // restarts land on pixel boundaries so the phase stays aligned
    for (int i = 0; i < 9; i++) begin
      k = i == 0 ? 1 : i == 1 ? 7 : 2 + rnd() % 6;
      nFire++;
      tick(1'b1);
      repeat (6 * k - 1) tick(1'b0);
      $display("start %0d spacing %0d done", i, 6 * k);
    end
    repeat (36) tick(1'b0);
    chk(6'(nRise), 6'(nFire));
    // enable low must freeze every output
    held = outs;
    clkEn <= 1'b0;
    repeat (10) begin
      @(negedge clock);
      chk(outs, held);
    end
    clkEn <= 1'b1;
    $display("freeze test done");
    close_out();
  end
  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end
endmodule // linear_sensor_scan_timing_test
`default_nettype wire
